// File: rtl/ppcl_defines.vh
// Constants for the passive parallel configuration load block
`ifndef PPCL_DEFINES_VH
`define PPCL_DEFINES_VH
`define PPCL_DATA_W 32
`define PPCL_FIFO_DEPTH 32
`define PPCL_FIFO_AW 5
`define PPCL_POR_NS 1000
`define PPCL_CLK_NS 10
`define PPCL_POR_CYCLES ((`PPCL_POR_NS + `PPCL_CLK_NS - 1) / `PPCL_CLK_NS)
`define PPCL_IMAGE_WORDS 64
`define PPCL_RATIO_PLAIN 3'h1
`define PPCL_RATIO_COMP 3'h4
`define PPCL_RATIO_SEC 3'h4
`define PPCL_RATIO_BOTH 3'h4
`define PPCL_OPT_WORD 0
`define PPCL_OPT_INIT_BIT 0
`define PPCL_INIT_EDGES 2'h2
`define PPCL_ST_POR 3'h0
`define PPCL_ST_WAIT 3'h1
`define PPCL_ST_LOAD 3'h2
`define PPCL_ST_INIT 3'h3
`define PPCL_ST_USER 3'h4
`endif

// File: rtl/ppcl_fifo.v
// Word FIFO between the configuration pins and the image sink
`timescale 1ns/1ps
module ppcl_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire resetn,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_reg;
    reg [AW:0] rd_reg;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;
    assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign empty = (wr_reg == rd_reg);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign do_wr = in_valid && !full;
    assign do_rd = out_ready && !empty;
    always @* begin
        out_data = mem[rd_reg[AW-1:0]];
    end
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (!resetn || flush) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// File: rtl/ppcl_load.v
// Passive parallel configuration load port, device side
// What this block and its host do
// [RL1] Request low in user mode restarts configuration
// [RL2] User mode: request, state, complete all high
// [RL3] State line low through power-on delay
// [RL4] Complete low until image fully received
// [RL5] Clock ignored once configuration is complete
// [RL6] Host keeps clock driven after completion
// [RL7] Host pauses with clock low, data first
// [RL8] Complete rises only after every word
// [RL9] Two falling edges start initialization, user mode
// [RL10] Enabled init pin goes low after option; the code pulls it low only once the load is over (INIT or USER state)
// [RL11] Clocks per word follow compression, security
// [RL12] Host holds word across ratio clocks
// [RL13] Data path 32 bits, one word per group
`timescale 1ns/1ps
`include "ppcl_defines.vh"
module ppcl_load #(
    parameter POR_CYCLES = `PPCL_POR_CYCLES,
    parameter IMAGE_WORDS = `PPCL_IMAGE_WORDS
) (
    input wire clk,
    input wire resetn,
    input wire config_request_n,
    input wire config_clock,
    input wire [31:0] config_data,
    input wire compress_en,
    input wire security_en,
    output wire config_state_n_out,
    output wire config_state_n_oe_n,
    input wire config_state_n_in,
    output wire load_complete_out,
    output wire load_complete_oe_n,
    input wire load_complete_in,
    output wire init_done_out,
    output wire init_done_oe_n,
    output reg user_mode,
    output reg image_valid,
    output reg [31:0] image_data,
    input wire image_ready,
    output reg load_error
);
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [1:0] req_sync_reg;
    reg [1:0] clk_sync_reg;
    reg [31:0] data_s1_reg;
    reg [31:0] data_s2_reg;
    reg clk_prev_reg;
    reg [1:0] stat_sync_reg;
    reg [1:0] done_sync_reg;
    reg [31:0] por_cnt_reg;
    reg [2:0] ratio_cnt_reg;
    reg [31:0] word_cnt_reg;
    reg [1:0] fall_cnt_reg;
    reg init_en_reg;
    reg init_low_reg;
    wire req_n;
    wire clk_rise;
    wire clk_fall;
    wire take_word;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [31:0] fifo_out_data;
    wire fifo_flush;
    wire [2:0] ratio;
    wire load_start;
    wire load_over;
    wire init_fall;

    function [2:0] ratio_of;
        input comp;
        input sec;
        begin
            case ({comp, sec})
                2'b00: ratio_of = `PPCL_RATIO_PLAIN;
                2'b01: ratio_of = `PPCL_RATIO_SEC;
                2'b10: ratio_of = `PPCL_RATIO_COMP;
                default: ratio_of = `PPCL_RATIO_BOTH;
            endcase
        end
    endfunction

    // Power-up and waiting states
    function before_load;
        input [2:0] st;
        begin
            before_load = (st == `PPCL_ST_POR) || (st == `PPCL_ST_WAIT);
        end
    endfunction

    assign ratio = ratio_of(compress_en, security_en); // [RL11]
    assign req_n = req_sync_reg[1];
    assign clk_rise = clk_sync_reg[1] && !clk_prev_reg;
    assign clk_fall = !clk_sync_reg[1] && clk_prev_reg;
    // Last clock of each group takes the word; pause keeps the count
    assign take_word = (state_reg == `PPCL_ST_LOAD) && clk_rise
        && (ratio_cnt_reg == ratio - 3'h1) && fifo_in_ready; // [RL7] [RL12] [RL13]
    assign load_start = before_load(state_reg) && (state_next == `PPCL_ST_LOAD);
    assign load_over = (state_reg == `PPCL_ST_INIT) || (state_reg == `PPCL_ST_USER);
    // Falls count only once the complete line reads high
    assign init_fall = (state_reg == `PPCL_ST_INIT) && done_sync_reg[1] && clk_fall; // [RL9]
    // Loaded words are dropped in power-up and while waiting for a load
    assign fifo_flush = before_load(state_reg);

    // Open-drain outputs: enable low means pulling the line low
    assign config_state_n_out = 1'b0;
    assign config_state_n_oe_n = !((state_reg == `PPCL_ST_POR) || !req_n); // [RL3]
    assign load_complete_out = 1'b0;
    assign load_complete_oe_n = !(before_load(state_reg) || (state_reg == `PPCL_ST_LOAD)); // [RL4] [RL8]
    assign init_done_out = 1'b0;
    assign init_done_oe_n = !init_low_reg; // [RL10]

    // Request synchroniser, idles high
    always @(posedge clk) begin
        if (!resetn) begin
            req_sync_reg <= 2'b11;
        end else begin
            req_sync_reg <= {req_sync_reg[0], config_request_n};
        end
    end

    // Clock synchroniser and edge memory, idles low
    always @(posedge clk) begin
        if (!resetn) begin
            clk_sync_reg <= 2'b00;
            clk_prev_reg <= 1'b0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], config_clock};
            clk_prev_reg <= clk_sync_reg[1];
        end
    end

    // Data synchroniser, same delay as the clock
    always @(posedge clk) begin
        data_s1_reg <= config_data;
        data_s2_reg <= data_s1_reg;
    end

    // Sensed status and complete lines, low in reset
    always @(posedge clk) begin
        if (!resetn) begin
            stat_sync_reg <= 2'b00;
            done_sync_reg <= 2'b00;
        end else begin
            stat_sync_reg <= {stat_sync_reg[0], config_state_n_in};
            done_sync_reg <= {done_sync_reg[0], load_complete_in};
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `PPCL_ST_POR: begin
                if (por_cnt_reg >= POR_CYCLES - 1) begin
                    state_next = `PPCL_ST_WAIT; // [RL3]
                end
            end
            `PPCL_ST_WAIT: begin
                if (req_n && stat_sync_reg[1]) begin // [RL3]
                    state_next = `PPCL_ST_LOAD;
                end
            end
            `PPCL_ST_LOAD: begin
                if (!req_n) begin
                    state_next = `PPCL_ST_WAIT;
                end else if (take_word && word_cnt_reg == IMAGE_WORDS - 1) begin
                    state_next = `PPCL_ST_INIT; // [RL8]
                end
            end
            `PPCL_ST_INIT: begin
                if (!req_n) begin
                    state_next = `PPCL_ST_WAIT;
                end else if (init_fall && fall_cnt_reg == `PPCL_INIT_EDGES - 2'h1) begin
                    state_next = `PPCL_ST_USER; // [RL9]
                end
            end
            `PPCL_ST_USER: begin
                if (!req_n) begin
                    state_next = `PPCL_ST_WAIT; // [RL1]
                end
            end
            default: state_next = `PPCL_ST_POR;
        endcase
    end

    // State register and user mode flag
    always @(posedge clk) begin
        if (!resetn) begin
            state_reg <= `PPCL_ST_POR;
            user_mode <= 1'b0;
        end else begin
            state_reg <= state_next;
            user_mode <= (state_next == `PPCL_ST_USER); // [RL2]
        end
    end

    // Power-on delay counter
    always @(posedge clk) begin
        if (!resetn) begin
            por_cnt_reg <= 32'h0;
        end else if (state_reg == `PPCL_ST_POR) begin
            por_cnt_reg <= por_cnt_reg + 32'h1; // [RL3]
        end
    end

    // Clock rises within the current word group
    always @(posedge clk) begin
        if (!resetn) begin
            ratio_cnt_reg <= 3'h0;
        end else if (state_reg != `PPCL_ST_LOAD) begin
            ratio_cnt_reg <= 3'h0; // [RL5]
        end else if (clk_rise && fifo_in_ready) begin
            ratio_cnt_reg <= (ratio_cnt_reg == ratio - 3'h1) ? 3'h0 : ratio_cnt_reg + 3'h1; // [RL11]
        end
    end

    // Words taken in this load
    always @(posedge clk) begin
        if (!resetn) begin
            word_cnt_reg <= 32'h0;
        end else if (load_start) begin
            word_cnt_reg <= 32'h0;
        end else if (take_word) begin
            word_cnt_reg <= word_cnt_reg + 32'h1; // [RL8]
        end
    end

    // Option bit from the first word
    always @(posedge clk) begin
        if (!resetn) begin
            init_en_reg <= 1'b0;
        end else if (load_start) begin
            init_en_reg <= 1'b0;
        end else if (take_word && word_cnt_reg == `PPCL_OPT_WORD) begin
            init_en_reg <= data_s2_reg[`PPCL_OPT_INIT_BIT]; // [RL10]
        end
    end

    // Init pin pulled once the load is over
    always @(posedge clk) begin
        if (!resetn) begin
            init_low_reg <= 1'b0;
        end else if (load_start) begin
            init_low_reg <= 1'b0;
        end else if (init_en_reg && load_over) begin
            init_low_reg <= 1'b1; // [RL10]
        end
    end

    // Falls after the complete line is up
    always @(posedge clk) begin
        if (!resetn) begin
            fall_cnt_reg <= 2'h0;
        end else if (state_reg != `PPCL_ST_INIT) begin
            fall_cnt_reg <= 2'h0;
        end else if (init_fall) begin
            fall_cnt_reg <= fall_cnt_reg + 2'h1; // [RL9]
        end
    end

    // Clock edges in a full buffer are lost and flagged
    always @(posedge clk) begin
        if (!resetn) begin
            load_error <= 1'b0;
        end else if (load_start) begin
            load_error <= 1'b0;
        end else if (state_reg == `PPCL_ST_LOAD && clk_rise && !fifo_in_ready) begin
            load_error <= 1'b1;
        end
    end

    ppcl_fifo #(
        .WIDTH(`PPCL_DATA_W),
        .DEPTH(`PPCL_FIFO_DEPTH),
        .AW(`PPCL_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .flush(fifo_flush),
        .in_valid(take_word),
        .in_ready(fifo_in_ready),
        .in_data(data_s2_reg),
        .out_valid(fifo_out_valid),
        .out_ready(image_ready || !image_valid),
        .out_data(fifo_out_data)
    );

    always @(posedge clk) begin
        if (!resetn || fifo_flush) begin
            image_valid <= 1'b0;
            image_data <= 32'h0;
        end else if (image_ready || !image_valid) begin
            image_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                image_data <= fifo_out_data;
            end
        end
    end
endmodule

// File: sim/ppcl_load_props.sv
// Concurrent checks on the parallel load port
`timescale 1ns/1ps
module ppcl_load_props #(
    parameter POR_CYCLES = 10,
    parameter IMAGE_WORDS = 8
) (
    input wire clk,
    input wire resetn,
    input wire config_request_n,
    input wire config_state_n_oe_n,
    input wire load_complete_oe_n,
    input wire init_done_oe_n,
    input wire user_mode,
    input wire image_valid,
    input wire [31:0] image_data,
    input wire image_ready
);
    int out_cnt;
    logic opt_q;
    logic [4:0] req_hist;
    wire quiet = &req_hist && user_mode;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Words handed out, first option bit
    always @(posedge clk) begin
        req_hist <= resetn ? {req_hist[3:0], config_request_n} : 5'h0;
        if (!resetn || !config_request_n)
            out_cnt <= 0;
        else if (image_valid && image_ready) begin
            out_cnt <= out_cnt + 1;
            if (out_cnt == 0)
                opt_q <= image_data[0];
        end
    end
    por_hold_a: assert property (!$past(resetn) |-> !config_state_n_oe_n [*8])
        else $error("status released early");
    user_lines_a: assert property (quiet |-> config_state_n_oe_n && load_complete_oe_n)
        else $error("status line low in user mode");
    user_restart_a: assert property (user_mode && !config_request_n |-> ##[1:6] !user_mode)
        else $error("request ignored in user mode");
    done_low_a: assert property ($fell(config_request_n) |-> ##[1:8] !load_complete_oe_n)
        else $error("complete not pulled low");
    clock_ignored_a: assert property (quiet |=> user_mode && !$rose(image_valid))
        else $error("user mode disturbed");
    all_words_a: assert property ($rose(load_complete_oe_n) |-> ##[0:60] out_cnt == IMAGE_WORDS)
        else $error("complete before all words");
    init_pin_a: assert property (quiet |-> init_done_oe_n == !opt_q)
        else $error("init pin wrong");
    word_hold_a: assert property (image_valid && !image_ready |=> image_valid && $stable(image_data))
        else $error("word dropped while stalled");
    cover property ($rose(user_mode));
    cover property ($fell(init_done_oe_n));
    cover property (image_valid && !image_ready);
endmodule
bind ppcl_load ppcl_load_props #(.POR_CYCLES(POR_CYCLES), .IMAGE_WORDS(IMAGE_WORDS)) u_props (
    .clk(clk),
    .resetn(resetn),
    .config_request_n(config_request_n),
    .config_state_n_oe_n(config_state_n_oe_n),
    .load_complete_oe_n(load_complete_oe_n),
    .init_done_oe_n(init_done_oe_n),
    .user_mode(user_mode),
    .image_valid(image_valid),
    .image_data(image_data),
    .image_ready(image_ready)
);

// File: sim/ppcl_host.sv
// Host model driving the parallel load pins
`timescale 1ns/1ps
module ppcl_host (
    output reg config_clock,
    output reg [31:0] config_data,
    input wire load_complete
);
    logic [31:0] sent[$];
    initial begin
        config_clock = 1'b0; // Always driven
        config_data = 32'h0;
    end
    task automatic pulse(input int n);
        repeat (n) begin
            #62.5 config_clock = 1'b1;
            #62.5 config_clock = 1'b0;
        end
    endtask
    task automatic load(input int n, input int r, input bit opt);
        logic [31:0] w;
        #3;
        for (int i = 0; i < n; i++) begin
            w = $urandom;
            if (i == 0)
                w[0] = opt; // Option bit in first word
            sent.push_back(w);
            config_data = w; // Data before first rise
            if ($urandom_range(3) == 0)
                #300; // Pause with clock low
            pulse(r); // Word held over r rises
        end
        #40 config_data = ~w;
        wait (load_complete === 1'b1);
        pulse(2); // Two falls into user mode
    endtask
endmodule

// File: sim/ppcl_load_tb.sv
// Self-checking bench for the parallel load port
`timescale 1ns/1ps
module ppcl_load_tb;
    localparam int NW = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic config_request_n = 1'b1;
    logic compress_en = 1'b0;
    logic security_en = 1'b0;
    logic image_ready = 1'b0;
    wire config_clock, config_state_n_out, config_state_n_oe_n, load_complete_out, load_complete_oe_n;
    wire init_done_out, init_done_oe_n, user_mode, image_valid, load_error;
    wire [31:0] config_data, image_data;
    wire config_state_n_in = config_state_n_oe_n ? 1'b1 : config_state_n_out;
    wire load_complete_in = load_complete_oe_n ? 1'b1 : load_complete_out;
    int err_count = 0;
    int comparisons = 0;
    int rcv = 0;
    always #5 clk = ~clk;
    ppcl_host host (.config_clock(config_clock), .config_data(config_data), .load_complete(load_complete_in));
    ppcl_load #(.POR_CYCLES(10), .IMAGE_WORDS(NW)) dut (
        .clk(clk),
        .resetn(resetn),
        .config_request_n(config_request_n),
        .config_clock(config_clock),
        .config_data(config_data),
        .compress_en(compress_en),
        .security_en(security_en),
        .config_state_n_out(config_state_n_out),
        .config_state_n_oe_n(config_state_n_oe_n),
        .config_state_n_in(config_state_n_in),
        .load_complete_out(load_complete_out),
        .load_complete_oe_n(load_complete_oe_n),
        .load_complete_in(load_complete_in),
        .init_done_out(init_done_out),
        .init_done_oe_n(init_done_oe_n),
        .user_mode(user_mode),
        .image_valid(image_valid),
        .image_data(image_data),
        .image_ready(image_ready),
        .load_error(load_error)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Sink with random stalls, compared with words sent
    always @(posedge clk) begin
        image_ready <= ($urandom_range(3) != 0);
        if (image_valid && image_ready) begin
            chk(image_data, host.sent.pop_front());
            rcv++;
        end
    end
    task automatic cfg(input int m);
        int r;
        r = (m == 0) ? 1 : 4;
        @(posedge clk);
        compress_en <= m[0];
        security_en <= m[1];
        config_request_n <= 1'b0;
        repeat (12) @(posedge clk);
        chk(user_mode, 1'b0);
        chk(load_complete_in, 1'b0);
        config_request_n <= 1'b1;
        rcv = 0;
        host.load(NW, r, m[0]);
        repeat (40) @(posedge clk);
        chk(rcv, NW);
        chk({user_mode, config_state_n_in, load_complete_in}, 3'h7);
        chk(init_done_oe_n, !m[0]);
        chk(load_error, 1'b0);
    endtask
    initial begin
        void'($urandom(45));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        chk({config_state_n_in, load_complete_in, user_mode}, 3'h0);
        for (int m = 0; m < 4; m++) begin
            cfg(m);
            host.pulse(6);
            repeat (5) @(posedge clk);
            chk(user_mode, 1'b1);
            chk(rcv, NW);
        end
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule
